/* pmc_consts.svh */
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH
// number of processor cores tracked
`define PMC_NUM_CPUS 2
// position of the deep sleep select bit in each core's control register
`define PMC_DEEP_SLEEP_SELECT_POS 2
// width of the peripheral wake interrupt bus
`define PMC_NUM_IRQS 8
// number of dedicated wake pins usable out of hibernate
`define PMC_NUM_WAKE_PINS 2
// width of the gpio output bank frozen in hibernate
`define PMC_GPIO_WIDTH 16
// cycles the reset sequence is held after a hibernate wake
`define PMC_HIB_RESET_CYCLES 8'h10
`endif

/* pmc_pkg.sv */
package pmc_pkg;
   // system wide power modes
   typedef enum logic [1:0] {
      full_power_system_mode = 2'b00,
      reduced_voltage_system_mode = 2'b01,
      sys_deep_sleep = 2'b10,
      sys_hibernate = 2'b11
   } sys_mode_t;
   // per-core power states
   typedef enum logic [1:0] {
      cpu_running = 2'b00,
      cpu_sleep = 2'b01,
      cpu_deep_sleep = 2'b10
   } cpu_state_t;
   // one core's sleep request signals
   typedef struct packed {
      logic wfi;
      logic wfe;
      logic sev;
      logic deep_sleep_select_bit;
   } cpu_req_t;
   // resource enables shown to the rest of the chip
   typedef struct packed {
      logic hf_clk_en;
      logic hf_clk_reduced;
      logic lf_clk_en;
      logic sram_retain;
      logic periph_en;
      logic lp_analog_en;
      logic backup_en;
   } power_ctl_t;
endpackage

/* cpu_sleep_tracker.sv */
`timescale 1ns/1ps
`include "pmc_consts.svh"
// one core's running / sleep / deep sleep tracker
module cpu_sleep_tracker (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic sleep_cmd_i,      // wfi or wfe seen this cycle
   input wire logic by_event_i,       // sleep entered through wfe
   input wire logic deep_sel_i,       // deep sleep select bit
   input wire logic irq_wake_i,       // enabled interrupt pending
   input wire logic event_wake_i,     // event from other core or wake
   input wire logic allow_i,          // system is in a running mode
   output pmc_pkg::cpu_state_t state_o,
   output logic halted_o
);
   import pmc_pkg::*;
   cpu_state_t state_reg;
   cpu_state_t state_next;
   logic evt_reg;                     // core sleeps waiting for event
   logic evt_next;
   // wake term depends on how the core went to sleep
   wire wake_w = irq_wake_i | (evt_reg & event_wake_i);

   // next state, independent of the other core
   always_comb begin
      state_next = state_reg;
      evt_next = evt_reg;
      case (state_reg)
         cpu_running: begin
            // RULE16 independent per core
            if (sleep_cmd_i && allow_i) begin
               // RULE15 deep select before sleep
               state_next = deep_sel_i ? cpu_deep_sleep : cpu_sleep;
               evt_next = by_event_i;
            end
         end
         cpu_sleep, cpu_deep_sleep: begin
            // RULE12 interrupt ends sleep
            // RULE13 event wakes wfe sleeper
            if (wake_w) begin
               state_next = cpu_running;
               evt_next = 1'b0;
            end
         end
         default: begin
            state_next = cpu_running;
            evt_next = 1'b0;
         end
      endcase
   end

   // state register, frozen with clock enable
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= cpu_running;
         evt_reg <= 1'b0;
      end else if (ce_i) begin
         state_reg <= state_next;
         evt_reg <= evt_next;
      end
   end

   assign state_o = state_reg;
   // RULE5 deep sleep halts execution
   assign halted_o = (state_reg != cpu_running);
endmodule

/* power_mode_controller.sv */
`timescale 1ns/1ps
`include "pmc_consts.svh"
// Notes on behaviour
// RULE1 - seven modes: four system, three per core
// RULE2 - core states only in full or reduced
// RULE3 - full power mode: everything at full speed
// RULE4 - reduced mode: high clocks limited
// RULE5 - core deep sleep halts, requests system deep
// RULE6 - system deep only when all cores deep
// RULE7 - deep sleep: high clocks off, sram kept
// RULE8 - deep sleep: analog, some digital wake
// RULE9 - hibernate: all off, gpio outputs frozen
// RULE10 - hibernate wake: comparator, rtc alarm, pins
// RULE11 - hibernate: sram lost, backup kept
// RULE12 - wfi sleeps until any interrupt; here only interrupts enabled in irq_wake_en_i end it
// RULE13 - wfe sleeper wakes on event
// RULE14 - set event wakes other wfe sleepers
// RULE15 - deep select bit set before sleep
// RULE16 - each core tracked independently
// RULE17 - enabled wake interrupt wakes everything
// RULE18 - hibernate wake restarts through reset
module power_mode_controller #(
   parameter int NUM_CPUS = `PMC_NUM_CPUS,
   parameter int NUM_IRQS = `PMC_NUM_IRQS,
   parameter int NUM_WAKE_PINS = `PMC_NUM_WAKE_PINS,
   parameter int GPIO_WIDTH = `PMC_GPIO_WIDTH
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // core side: sleep, event and select from each core
   input pmc_pkg::cpu_req_t [NUM_CPUS-1:0] cpu_req_i,
   // system level requests from the power policy logic
   input wire logic reduced_mode_req_i,
   input wire logic hibernate_req_i,
   // peripheral interrupt levels and their wake masks
   input wire logic [NUM_IRQS-1:0] irq_i,
   input wire logic [NUM_IRQS-1:0] irq_wake_en_i,
   input wire logic [NUM_IRQS-1:0] irq_deep_capable_i,
   // hibernate wake sources, asynchronous to clk_i
   input wire logic lp_comparator_i,
   input wire logic rtc_alarm_i,
   input wire logic [NUM_WAKE_PINS-1:0] wake_pin_i,
   // values the chip's logic wants on its pins
   input wire logic [GPIO_WIDTH-1:0] gpio_out_i,
   // every output below is a flip-flop
   output pmc_pkg::sys_mode_t sys_mode_o,
   output pmc_pkg::cpu_state_t [NUM_CPUS-1:0] cpu_state_o,
   output logic [NUM_CPUS-1:0] cpu_halt_o,
   output logic [NUM_CPUS-1:0] cpu_event_o,
   // resource enables for clocks, sram and analog
   output pmc_pkg::power_ctl_t power_ctl_o,
   output logic [GPIO_WIDTH-1:0] gpio_out_o,
   output logic gpio_frozen_o,
   output logic hib_reset_n_o
);
   import pmc_pkg::*;

   // RULE1 four system modes here, three core modes per tracker
   // system mode state
   sys_mode_t mode_reg;
   sys_mode_t mode_next;
   // mode to return to after system deep sleep
   logic reduced_reg;
   // gpio latch and freeze flag
   logic [GPIO_WIDTH-1:0] gpio_reg;
   logic frozen_reg;
   // reset sequence counter after hibernate wake
   logic [7:0] rst_cnt_reg;
   logic hib_rst_n_reg;
   // registered outputs
   power_ctl_t pctl_reg;
   power_ctl_t pctl_next;
   // per-core output copies
   cpu_state_t [NUM_CPUS-1:0] cstate_reg;
   logic [NUM_CPUS-1:0] halt_reg;
   logic [NUM_CPUS-1:0] evt_out_reg;

   // hibernate wake pins come from outside the clock domain
   // bit order: pins low, then comparator, then alarm
   logic [NUM_WAKE_PINS+1:0] hwake_meta_reg;
   logic [NUM_WAKE_PINS+1:0] hwake_sync_reg;

   // per-core tracker outputs
   cpu_state_t [NUM_CPUS-1:0] cstate_w;
   logic [NUM_CPUS-1:0] halt_w;
   logic [NUM_CPUS-1:0] deep_w;
   // set event pulses from each core and the fan-out to each
   logic [NUM_CPUS-1:0] sev_w;
   logic [NUM_CPUS-1:0] event_to_w;

   // same clock domain as the interrupts, so no synchroniser
   // RULE17 enabled wake interrupts
   wire irq_wake_w = |(irq_i & irq_wake_en_i);
   // RULE8 only deep capable sources work in deep sleep
   wire deep_wake_w = |(irq_i & irq_wake_en_i & irq_deep_capable_i);
   // RULE10 only these three wake from hibernate
   // synchronised copies only; raw pins never reach the mode logic
   wire hib_wake_w = |hwake_sync_reg;
   // RULE2 core states exist only in running system modes
   wire run_mode_w = (mode_reg == full_power_system_mode) || (mode_reg == reduced_voltage_system_mode);
   // RULE6 every core in deep sleep
   wire all_deep_w = &deep_w;
   // RULE17 cores wake with the system
   // core wake feed: any wake interrupt while running; in system deep sleep only the deep
   // capable ones, in the same cycle as the system wakes, so a short pulse cannot leave the
   // cores deep and pull the system straight back into deep sleep
   wire core_irq_w = run_mode_w ? irq_wake_w : ((mode_reg == sys_deep_sleep) && deep_wake_w);

   // one tracker per core, events fanned between them
   // separate trackers keep the cores' sleep states uncoupled
   genvar g;
   generate
      for (g = 0; g < NUM_CPUS; g = g + 1) begin : gen_cpu
         // RULE14 set event from any other core
         assign event_to_w[g] = |(sev_w & ~(NUM_CPUS'(1) << g));
         assign sev_w[g] = cpu_req_i[g].sev;
         // RULE5 a deep core raises its system deep sleep request
         assign deep_w[g] = (cstate_w[g] == cpu_deep_sleep);
         // trackers restart with the chip after a hibernate wake
         cpu_sleep_tracker u_trk (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i & hib_rst_n_reg),
            .ce_i(ce_i),
            .sleep_cmd_i(cpu_req_i[g].wfi | cpu_req_i[g].wfe),
            .by_event_i(cpu_req_i[g].wfe & ~cpu_req_i[g].wfi),
            .deep_sel_i(cpu_req_i[g].deep_sleep_select_bit),
            .irq_wake_i(core_irq_w),
            .event_wake_i(event_to_w[g] | core_irq_w),
            .allow_i(run_mode_w),
            .state_o(cstate_w[g]),
            .halted_o(halt_w[g])
         );
      end
   endgenerate

   // system mode next state
   always_comb begin
      mode_next = mode_reg;
      case (mode_reg)
         full_power_system_mode, reduced_voltage_system_mode: begin
            // RULE2 core states change only in these two modes
            // hibernate wins when both hibernate and deep sleep are due
            if (hibernate_req_i) begin
               // RULE9 hibernate entry
               mode_next = sys_hibernate;
            end else if (all_deep_w) begin
               // RULE6 enter deep sleep only when all deep
               mode_next = sys_deep_sleep;
            end else begin
               // awake: follow the reduced voltage request
               mode_next = reduced_mode_req_i ? reduced_voltage_system_mode : full_power_system_mode;
            end
         end
         sys_deep_sleep: begin
            // RULE17 wake from system deep sleep
            // RULE8 only deep capable enabled sources count here
            // the voltage setting comes back as it was before sleeping
            if (deep_wake_w) begin
               mode_next = reduced_reg ? reduced_voltage_system_mode : full_power_system_mode;
            end
         end
         sys_hibernate: begin
            // RULE18 wake leaves via reset sequence
            // full power is the safe restart while the chip is held in reset
            if (hib_wake_w) begin
               mode_next = full_power_system_mode;
            end
         end
         // unused code: fall back to full power
         default: mode_next = full_power_system_mode;
      endcase
   end

   // resource enables for each system mode
   always_comb begin
      // backup domain and low clock on unless a mode turns them off
      pctl_next = '0;
      pctl_next.backup_en = 1'b1;
      pctl_next.lf_clk_en = 1'b1;
      case (mode_next)
         full_power_system_mode: begin
            // RULE3 full speed everything
            pctl_next.hf_clk_en = 1'b1;
            pctl_next.periph_en = 1'b1;
            pctl_next.lp_analog_en = 1'b1;
            pctl_next.sram_retain = 1'b1;
         end
         reduced_voltage_system_mode: begin
            // RULE4 clocks limited at low core voltage
            pctl_next.hf_clk_en = 1'b1;
            pctl_next.hf_clk_reduced = 1'b1;
            pctl_next.periph_en = 1'b1;
            pctl_next.lp_analog_en = 1'b1;
            pctl_next.sram_retain = 1'b1;
         end
         sys_deep_sleep: begin
            // RULE7 high clocks off, sram kept
            // RULE8 low power analog kept for wake
            pctl_next.lp_analog_en = 1'b1;
            // periph_en stays off: most digital blocks are unpowered
            pctl_next.sram_retain = 1'b1;
         end
         sys_hibernate: begin
            // RULE11 sram lost, backup kept
            // RULE9 low clock off too
            pctl_next.lf_clk_en = 1'b0;
            // RULE10 comparator stays powered so it can wake the chip
            pctl_next.lp_analog_en = 1'b1;
         end
         // unused code: everything off
         default: pctl_next = '0;
      endcase
   end

   // wake pin synchronisers, first stage read only by the second
   // the pins may move at any instant, so only the second stage feeds logic
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         // wake sources read as idle in reset
         hwake_meta_reg <= '0;
         hwake_sync_reg <= '0;
      end else if (ce_i) begin
         hwake_meta_reg <= {rtc_alarm_i, lp_comparator_i, wake_pin_i};
         hwake_sync_reg <= hwake_meta_reg;
      end
   end

   // system mode, return mode and registered outputs
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         // come up in full power, enables gated until the first edge
         mode_reg <= full_power_system_mode;
         reduced_reg <= 1'b0;
         pctl_reg <= '0;
      end else if (ce_i) begin
         mode_reg <= mode_next;
         // enables follow the mode taken at the same edge
         pctl_reg <= pctl_next;
         // remember the running voltage so a deep sleep wake returns to it
         if (run_mode_w) begin
            reduced_reg <= reduced_mode_req_i;
         end
      end
   end

   // core state copies; cores forced off outside running modes
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cstate_reg <= '0;
         halt_reg <= '0;
         evt_out_reg <= '0;
      end else if (ce_i) begin
         // one cycle behind the trackers
         cstate_reg <= cstate_w;
         // RULE5 deep sleep core stops executing
         halt_reg <= halt_w | {NUM_CPUS{~run_mode_w}};
         // RULE14 one-cycle event pulse towards each core
         evt_out_reg <= event_to_w;
      end
   end

   // gpio freeze: hold last driven value through hibernate
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         // pins low and unfrozen in reset
         gpio_reg <= '0;
         frozen_reg <= 1'b0;
      end else if (ce_i) begin
         // RULE9 outputs held while hibernating
         frozen_reg <= (mode_next == sys_hibernate);
         // latch follows the logic except while hibernating
         if (mode_next != sys_hibernate) begin
            gpio_reg <= gpio_out_i;
         end
      end
   end

   // reset pulse after hibernate wake; sram contents are gone, so no resume
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         // chip reset released while rst_n_i itself holds everything
         rst_cnt_reg <= '0;
         hib_rst_n_reg <= 1'b1;
      end else if (ce_i) begin
         // RULE18 restart through reset
         if (mode_reg == sys_hibernate && hib_wake_w) begin
            rst_cnt_reg <= `PMC_HIB_RESET_CYCLES;
            hib_rst_n_reg <= 1'b0;
         end else if (rst_cnt_reg != 8'h00) begin
            // count down, release on the last count
            rst_cnt_reg <= rst_cnt_reg - 8'h01;
            hib_rst_n_reg <= (rst_cnt_reg == 8'h01);
         end
      end
   end

   // every output is a plain register copy
   assign sys_mode_o = mode_reg;
   assign cpu_state_o = cstate_reg;
   assign cpu_halt_o = halt_reg;
   assign cpu_event_o = evt_out_reg;
   assign power_ctl_o = pctl_reg;
   assign gpio_out_o = gpio_reg;
   assign gpio_frozen_o = frozen_reg;
   assign hib_reset_n_o = hib_rst_n_reg;
endmodule

/* pmc_core_model.sv */
`timescale 1ns/1ps
// one processor core issuing sleep and event instructions
module pmc_core_model (
   input wire logic clk_i,
   output pmc_pkg::cpu_req_t req_o
);
   import pmc_pkg::*;
   // idle core: no instruction, light sleep selected
   initial req_o = '0;
   // select is set a cycle ahead, though the controller reads it in the same cycle as the sleep command
   // select before sleep
   task automatic sleep(input logic deep, input logic by_event);
      @(negedge clk_i);
      req_o.deep_sleep_select_bit = deep;
      @(negedge clk_i);
      req_o.wfi = !by_event;
      req_o.wfe = by_event;
      @(negedge clk_i);
      req_o.wfi = 1'b0;
      req_o.wfe = 1'b0;
   endtask
   // one cycle set event pulse
   task automatic set_event();
      @(negedge clk_i);
      req_o.sev = 1'b1;
      @(negedge clk_i);
      req_o.sev = 1'b0;
   endtask
endmodule

/* power_mode_controller_asserts.sv */
`timescale 1ns/1ps
`include "pmc_consts.svh"
// mode side effects, seen only at the controller pins
module power_mode_controller_asserts #(
   parameter int NUM_CPUS = 2,
   parameter int NUM_IRQS = 8,
   parameter int NUM_WAKE_PINS = 2,
   parameter int GPIO_WIDTH = 16
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input pmc_pkg::cpu_req_t [NUM_CPUS-1:0] cpu_req_i,
   input wire logic reduced_mode_req_i,
   input wire logic hibernate_req_i,
   input wire logic [NUM_IRQS-1:0] irq_i,
   input wire logic [NUM_IRQS-1:0] irq_wake_en_i,
   input wire logic [NUM_IRQS-1:0] irq_deep_capable_i,
   input wire logic lp_comparator_i,
   input wire logic rtc_alarm_i,
   input wire logic [NUM_WAKE_PINS-1:0] wake_pin_i,
   input wire logic [GPIO_WIDTH-1:0] gpio_out_i,
   input pmc_pkg::sys_mode_t sys_mode_o,
   input pmc_pkg::cpu_state_t [NUM_CPUS-1:0] cpu_state_o,
   input wire logic [NUM_CPUS-1:0] cpu_halt_o,
   input wire logic [NUM_CPUS-1:0] cpu_event_o,
   input pmc_pkg::power_ctl_t power_ctl_o,
   input wire logic [GPIO_WIDTH-1:0] gpio_out_o,
   input wire logic gpio_frozen_o,
   input wire logic hib_reset_n_o
);
   import pmc_pkg::*;
   localparam int HibCyc = `PMC_HIB_RESET_CYCLES; // chip reset length after a hibernate wake
   logic [7:0] low_cnt; // cycles the chip reset has stayed low
   logic [NUM_CPUS-1:0] deep_v; // cores reporting deep sleep
   logic run_w; // system in a running mode
   logic wake_w; // any hibernate wake source
   assign run_w = (sys_mode_o == full_power_system_mode) || (sys_mode_o == reduced_voltage_system_mode);
   assign wake_w = lp_comparator_i | rtc_alarm_i | (|wake_pin_i);
   for (genvar i = 0; i < NUM_CPUS; i++) begin : g_deep
      assign deep_v[i] = (cpu_state_o[i] == cpu_deep_sleep);
   end
   // length counter: a 16 cycle repetition would be too costly to unroll
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         low_cnt <= 8'h00;
      end else begin
         low_cnt <= hib_reset_n_o ? 8'h00 : low_cnt + 8'h01;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_deep_in; (sys_mode_o != sys_deep_sleep) ##1 (sys_mode_o == sys_deep_sleep); endsequence
   sequence s_hib_out; (sys_mode_o == sys_hibernate) ##1 (sys_mode_o != sys_hibernate); endsequence
   property p_deep_in; s_deep_in |-> (&deep_v) && (&cpu_halt_o); endproperty
   property p_deep_res; sys_mode_o == sys_deep_sleep |-> !power_ctl_o.hf_clk_en && power_ctl_o.lf_clk_en
      && power_ctl_o.sram_retain && power_ctl_o.lp_analog_en; endproperty
   property p_full; (sys_mode_o == full_power_system_mode) [*3] |-> power_ctl_o.hf_clk_en
      && !power_ctl_o.hf_clk_reduced && power_ctl_o.periph_en; endproperty
   property p_reduced; (sys_mode_o == reduced_voltage_system_mode) [*3] |-> power_ctl_o.hf_clk_en
      && power_ctl_o.hf_clk_reduced && power_ctl_o.periph_en; endproperty
   property p_hib; sys_mode_o == sys_hibernate |-> gpio_frozen_o && !power_ctl_o.hf_clk_en
      && !power_ctl_o.sram_retain && power_ctl_o.backup_en && power_ctl_o.lp_analog_en; endproperty
   property p_hold; gpio_frozen_o && $past(gpio_frozen_o) |-> $stable(gpio_out_o); endproperty
   property p_hib_only; (sys_mode_o == sys_hibernate && !wake_w) [*4] |=> sys_mode_o == sys_hibernate; endproperty
   property p_hib_out; s_hib_out |-> !hib_reset_n_o && sys_mode_o == full_power_system_mode; endproperty
   property p_rst_len; $rose(hib_reset_n_o) |-> low_cnt == HibCyc; endproperty
   property p_event; cpu_req_i[0].sev && run_w && ce_i |-> ##[1:2] cpu_event_o[NUM_CPUS-1]; endproperty
   a_deep_in:
      assert property (p_deep_in) else $error("deep sleep entered while a core was not deep");
   a_deep_res:
      assert property (p_deep_res) else $error("wrong resources in deep sleep");
   a_full:
      assert property (p_full) else $error("full power mode not at full speed");
   a_reduced:
      assert property (p_reduced) else $error("reduced mode clocks not limited");
   a_hib:
      assert property (p_hib) else $error("wrong resources in hibernate");
   a_hold:
      assert property (p_hold) else $error("gpio outputs moved while frozen");
   a_hib_only:
      assert property (p_hib_only) else $error("hibernate left without a wake source");
   a_hib_out:
      assert property (p_hib_out) else $error("hibernate wake did not restart the chip");
   a_rst_len:
      assert property (p_rst_len) else $error("chip reset pulse has wrong length");
   a_event:
      assert property (p_event) else $error("set event not passed to the other core");
endmodule
bind power_mode_controller power_mode_controller_asserts #(
   .NUM_CPUS(NUM_CPUS), .NUM_IRQS(NUM_IRQS), .NUM_WAKE_PINS(NUM_WAKE_PINS), .GPIO_WIDTH(GPIO_WIDTH)
) u_pmc_chk (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .cpu_req_i(cpu_req_i),
   .reduced_mode_req_i(reduced_mode_req_i), .hibernate_req_i(hibernate_req_i), .irq_i(irq_i),
   .irq_wake_en_i(irq_wake_en_i), .irq_deep_capable_i(irq_deep_capable_i), .lp_comparator_i(lp_comparator_i),
   .rtc_alarm_i(rtc_alarm_i), .wake_pin_i(wake_pin_i), .gpio_out_i(gpio_out_i), .sys_mode_o(sys_mode_o),
   .cpu_state_o(cpu_state_o), .cpu_halt_o(cpu_halt_o), .cpu_event_o(cpu_event_o), .power_ctl_o(power_ctl_o),
   .gpio_out_o(gpio_out_o), .gpio_frozen_o(gpio_frozen_o), .hib_reset_n_o(hib_reset_n_o)
);

/* test_power_mode_controller.sv */
`timescale 1ns/1ps
// directed and random run through the controller's power modes
module test_power_mode_controller;
   import pmc_pkg::*;
   // one expected snapshot of the pins
   typedef struct packed {
      sys_mode_t m;
      cpu_state_t s1;
      cpu_state_t s0;
      logic [1:0] h; // core halt flags, core 1 first
      logic hf;
      logic fr;
      logic hr;
      logic [15:0] g;
   } snap_t;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic ce_i = 1'b1; // state never frozen in this run
   logic red_i = 1'b0; // reduced voltage request
   logic hib_i = 1'b0; // hibernate request
   logic [7:0] irq_i = 8'h00;
   logic [7:0] wen_i = 8'h00; // interrupt wake enables
   logic [7:0] cap_i = 8'h0f; // low half stays alive in deep sleep
   logic [3:0] wsrc = 4'h0; // pins, alarm, comparator
   logic [15:0] gpio_i = 16'h0000;
   cpu_req_t req0;
   cpu_req_t req1;
   sys_mode_t sys_mode_o;
   cpu_state_t [1:0] st_o;
   power_ctl_t pctl_o;
   logic [15:0] gpio_o;
   logic [1:0] halt_o; // cores not executing
   logic frz_o;
   logic hr_o;
   int num_errors = 0;
   int n_tests = 0;
   snap_t exp_q[$]; // notes waiting for the monitor
   event chk_ev; // a note falls due
   logic [15:0] g_exp; // gpio value the pins should show
   always #20 clk_i = ~clk_i;
   pmc_core_model core0 (.clk_i(clk_i), .req_o(req0));
   pmc_core_model core1 (.clk_i(clk_i), .req_o(req1));
   power_mode_controller DUT (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .cpu_req_i({req1, req0}), .reduced_mode_req_i(red_i),
      .hibernate_req_i(hib_i), .irq_i(irq_i), .irq_wake_en_i(wen_i), .irq_deep_capable_i(cap_i),
      .lp_comparator_i(wsrc[0]), .rtc_alarm_i(wsrc[1]), .wake_pin_i(wsrc[3:2]), .gpio_out_i(gpio_i),
      .sys_mode_o(sys_mode_o), .cpu_state_o(st_o), .cpu_halt_o(halt_o), .cpu_event_o(), .power_ctl_o(pctl_o),
      .gpio_out_o(gpio_o), .gpio_frozen_o(frz_o), .hib_reset_n_o(hr_o)
   );
   // report and count any difference
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_tests++;
      if (seen !== want) begin
         num_errors++;
         $display("ERROR %0t: pins %h expected %h", $time, seen, want);
      end
   endtask
   // note what the pins must show now, then wake the monitor
   task automatic expect_now(input sys_mode_t m, input cpu_state_t s0, input cpu_state_t s1, input logic hr);
      logic off;
      off = (m == sys_hibernate) || (m == sys_deep_sleep); // cores never execute here
      exp_q.push_back({m, s1, s0, off || s1 != cpu_running, off || s0 != cpu_running, !off, m == sys_hibernate, hr,
                       g_exp});
      -> chk_ev;
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // monitor: oldest note against the pins as they stand
   initial begin
      forever begin
         @(chk_ev);
         check(32'({sys_mode_o, st_o[1], st_o[0], halt_o, pctl_o.hf_clk_en, frz_o, hr_o, gpio_o}),
               32'(exp_q.pop_front()));
      end
   end
   // watchdog: the whole run needs some 180 cycles
   initial begin
      repeat (5000) @(posedge clk_i);
      num_errors++;
      close_out();
   end
   // main sequence
   initial begin
      void'($urandom(32'h4267));
      gpio_i = 16'($urandom);
      g_exp = gpio_i;
      step(4);
      rst_n_i = 1'b1;
      step(3);
      expect_now(full_power_system_mode, cpu_running, cpu_running, 1'b1);
      irq_i = 8'($urandom) | 8'h01;
      core0.sleep(1'b0, 1'b0);
      step(3);
      expect_now(full_power_system_mode, cpu_sleep, cpu_running, 1'b1);
      wen_i = 8'hff;
      step(4);
      expect_now(full_power_system_mode, cpu_running, cpu_running, 1'b1);
      irq_i = 8'h00;
      core1.sleep(1'b0, 1'b1);
      step(3);
      expect_now(full_power_system_mode, cpu_running, cpu_sleep, 1'b1);
      core0.set_event();
      step(4);
      expect_now(full_power_system_mode, cpu_running, cpu_running, 1'b1);
      $display("test light sleep and events done");
      red_i = 1'b1;
      step(4);
      expect_now(reduced_voltage_system_mode, cpu_running, cpu_running, 1'b1);
      core0.sleep(1'b1, 1'b0);
      step(3);
      expect_now(reduced_voltage_system_mode, cpu_deep_sleep, cpu_running, 1'b1);
      core1.sleep(1'b1, 1'b0);
      step(3);
      expect_now(sys_deep_sleep, cpu_deep_sleep, cpu_deep_sleep, 1'b1);
      irq_i = 8'h10;
      step(5);
      expect_now(sys_deep_sleep, cpu_deep_sleep, cpu_deep_sleep, 1'b1);
      irq_i = 8'h11;
      step(6);
      expect_now(reduced_voltage_system_mode, cpu_running, cpu_running, 1'b1);
      irq_i = 8'h00;
      red_i = 1'b0;
      step(4);
      $display("test deep sleep done");
      for (int i = 0; i < 4; i++) begin
         hib_i = 1'b1;
         step(1);
         hib_i = 1'b0;
         step(1);
         gpio_i = 16'($urandom);
         irq_i = 8'hff;
         step(5);
         expect_now(sys_hibernate, cpu_running, cpu_running, 1'b1);
         irq_i = 8'h00;
         wsrc = 4'(1 << i);
         step(1);
         wsrc = 4'h0;
         g_exp = gpio_i;
         step(4);
         expect_now(full_power_system_mode, cpu_running, cpu_running, 1'b0);
         step(18);
         expect_now(full_power_system_mode, cpu_running, cpu_running, 1'b1);
         $display("test hibernate wake source %0d done", i);
      end
      close_out();
   end
endmodule
